// *** src/ars_pkg.sv ***
// Purpose: Shared constants and carriers for the analog reference select bank.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes:   Register indexes are word indexes; byte address is four times the index.
`default_nettype none
package ars_pkg;

  localparam int unsigned ARS_ADDR_W  = 8;
  localparam int unsigned ARS_DATA_W  = 32;
  localparam int unsigned ARS_NUM_CMP = 4;
  localparam int unsigned ARS_REQ_W   = ARS_NUM_CMP + 2;

  // Register indexes
  localparam logic [5:0] ARS_IDX_CONVERTER  = 6'h00;
  localparam logic [5:0] ARS_IDX_RSVD_A     = 6'h01;
  localparam logic [5:0] ARS_IDX_DAC        = 6'h02;
  localparam logic [5:0] ARS_IDX_RSVD_B     = 6'h03;
  localparam logic [5:0] ARS_IDX_COMPARATOR = 6'h04;
  localparam logic [5:0] ARS_IDX_STATUS     = 6'h05;

  // Field layout of a reference setting
  localparam int unsigned ARS_KEEP_BIT  = 7;
  localparam int unsigned ARS_SEL_MSB   = 2;
  localparam logic [7:0]  ARS_REF_RESET = 8'h00;
  localparam logic [7:0]  ARS_REF_MASK  = 8'h87;

  // Status register bit positions
  localparam int unsigned ARS_ST_EN_LSB  = 0;
  localparam int unsigned ARS_ST_REQ_LSB = 4;

  localparam logic [1:0] ARS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ARS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ARS_SEL_LOWEST   = 3'h0,
    ARS_SEL_SECOND   = 3'h1,
    ARS_SEL_HIGHEST  = 3'h2,
    ARS_SEL_TWO_FIVE = 3'h3,
    ARS_SEL_RSVD_4   = 3'h4,
    ARS_SEL_SUPPLY   = 3'h5,
    ARS_SEL_EXT_PIN  = 3'h6,
    ARS_SEL_RSVD_7   = 3'h7
  } ars_level_e;

  typedef struct packed {
    logic       keep_source_powered;
    logic [3:0] unused;
    ars_level_e level_select;
  } ars_ref_reg_s;

  // Drive toward one analog consumer
  typedef struct packed {
    logic       source_enable;
    ars_level_e level_select;
    logic [3:0] internal_level;
    logic       route_supply;
    logic       route_external_pin;
    logic       code_reserved;
  } ars_ref_out_s;

  typedef struct packed {
    logic                  awvalid;
    logic [ARS_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [ARS_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [ARS_ADDR_W-1:0] araddr;
    logic                  rready;
  } ars_axi_req_s;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [ARS_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } ars_axi_rsp_s;

endpackage
`default_nettype wire

// *** src/ars_sync.sv ***
// Purpose: Two-flop synchroniser for request levels from the analog consumers.
// Assumes: Inputs are levels, not pulses.
// Notes:   First stage is read by the second stage only.
`default_nettype none
`timescale 1ns/100ps
module ars_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import ars_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ars_sync_s;

  ars_sync_s st;
  ars_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule
`default_nettype wire

// *** src/ars_ref_chan.sv ***
// Purpose: One reference source: enable on request or override, route the level.
// Assumes: Request is already synchronised to clk.
// Notes:   Reserved codes leave every route off so no undefined level reaches a consumer.
`default_nettype none
`timescale 1ns/100ps
module ars_ref_chan (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire ars_pkg::ars_ref_reg_s setting,
  input  wire logic                  request,
  output ars_pkg::ars_ref_out_s      drive
);
  import ars_pkg::*;

  typedef struct packed {
    ars_ref_out_s drive;
  } ars_chan_s;

  ars_chan_s st;
  ars_chan_s next_st;

  always_comb begin
    next_st = '0;
    next_st.drive.source_enable = setting.keep_source_powered | request;
    next_st.drive.level_select  = setting.level_select;
    case (setting.level_select)
      ARS_SEL_LOWEST:   next_st.drive.internal_level = 4'h1;
      ARS_SEL_SECOND:   next_st.drive.internal_level = 4'h2;
      ARS_SEL_HIGHEST:  next_st.drive.internal_level = 4'h4;
      ARS_SEL_TWO_FIVE: next_st.drive.internal_level = 4'h8;
      ARS_SEL_SUPPLY:   next_st.drive.route_supply = 1'b1;
      ARS_SEL_EXT_PIN:  next_st.drive.route_external_pin = 1'b1;
      default:          next_st.drive.code_reserved = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign drive = st.drive;

endmodule
`default_nettype wire

// *** src/ars_reference_bank.sv ***
// Purpose: Reference select register bank on AXI4-Lite with request-driven enables.
// Assumes: Request lines come from other clock domains and are synchronised here.
// Notes:   One write and one read may be under way at once; a read answers one cycle after its address, a write two after its last handshake.
//
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
`timescale 1ns/100ps
module ars_reference_bank (
  input  wire logic                                   clk,
  input  wire logic                                   srst,
  input  wire ars_pkg::ars_axi_req_s                  axi_req,
  output ars_pkg::ars_axi_rsp_s                       axi_rsp,
  input  wire logic                                   converter_request,
  input  wire logic                                   dac_request,
  input  wire logic [ars_pkg::ARS_NUM_CMP-1:0]        comparator_request,
  output ars_pkg::ars_ref_out_s                       converter_ref,
  output ars_pkg::ars_ref_out_s                       dac_ref,
  output ars_pkg::ars_ref_out_s [ars_pkg::ARS_NUM_CMP-1:0] comparator_ref
);
  import ars_pkg::*;

  typedef struct packed {
    ars_ref_reg_s          converter_reference_setting;
    ars_ref_reg_s          dac_reference_setting;
    ars_ref_reg_s          comparator_reference_setting;
    logic                  aw_held;
    logic [ARS_ADDR_W-1:0] awaddr;
    logic                  w_held;
    logic [ARS_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [ARS_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } ars_bank_s;

  ars_bank_s st;
  ars_bank_s next_st;

  logic [ARS_REQ_W-1:0] raw_request;
  logic [ARS_REQ_W-1:0] request_sync;
  logic                 comparator_any;
  ars_ref_out_s         comparator_drive;

  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       do_write;
  logic [5:0] wr_index;
  logic [5:0] rd_index;

  // Requests cross from the consumers' own clocks
  assign raw_request = {comparator_request, dac_request, converter_request};

  ars_sync #(
    .WIDTH (ARS_REQ_W)
  ) u_req_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (raw_request),
    .sync_out (request_sync)
  );

  // Any comparator asking for the shared reference turns it on
  assign comparator_any = |request_sync[ARS_REQ_W-1:2];

  ars_ref_chan u_converter_chan (
    .clk     (clk),
    .srst    (srst),
    .setting (st.converter_reference_setting),
    .request (request_sync[0]),
    .drive   (converter_ref)
  );

  ars_ref_chan u_dac_chan (
    .clk     (clk),
    .srst    (srst),
    .setting (st.dac_reference_setting),
    .request (request_sync[1]),
    .drive   (dac_ref)
  );

  ars_ref_chan u_comparator_chan (
    .clk     (clk),
    .srst    (srst),
    .setting (st.comparator_reference_setting),
    .request (comparator_any),
    .drive   (comparator_drive)
  );

  // One shared drive fans out to every comparator
  always_comb begin
    for (int i = 0; i < ARS_NUM_CMP; i++) begin
      comparator_ref[i] = comparator_drive;
    end
  end

  // Handshakes: a held item blocks its channel until the response is taken
  assign aw_take  = axi_req.awvalid & axi_rsp.awready;
  assign w_take   = axi_req.wvalid & axi_rsp.wready;
  assign ar_take  = axi_req.arvalid & axi_rsp.arready;
  assign do_write = st.aw_held & st.w_held & ~st.bvalid;
  assign wr_index = st.awaddr[ARS_ADDR_W-1:2];
  assign rd_index = axi_req.araddr[ARS_ADDR_W-1:2];

  assign axi_rsp.awready = ~st.aw_held & ~st.bvalid;
  assign axi_rsp.wready  = ~st.w_held & ~st.bvalid;
  assign axi_rsp.bvalid  = st.bvalid;
  assign axi_rsp.bresp   = st.bresp;
  assign axi_rsp.arready = ~st.rvalid;
  assign axi_rsp.rvalid  = st.rvalid;
  assign axi_rsp.rdata   = st.rdata;
  assign axi_rsp.rresp   = st.rresp;

  // Keep only the documented bits so the unused ones stay zero
  function automatic ars_ref_reg_s ars_mask(input logic [7:0] value);
    ars_mask = ars_ref_reg_s'(value & ARS_REF_MASK);
  endfunction

  function automatic logic [ARS_DATA_W-1:0] ars_word(input ars_ref_reg_s value);
    ars_word = {24'h000000, value & ARS_REF_MASK};
  endfunction

  always_comb begin
    next_st = st;

    // Write address and data are taken in either order
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = axi_req.awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = axi_req.wdata;
      next_st.wstrb  = axi_req.wstrb;
    end

    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = ARS_RESP_OKAY;
      case (wr_index)
        ARS_IDX_CONVERTER: begin
          if (st.wstrb[0]) begin
            next_st.converter_reference_setting = ars_mask(st.wdata[7:0]);
          end
        end
        ARS_IDX_DAC: begin
          if (st.wstrb[0]) begin
            next_st.dac_reference_setting = ars_mask(st.wdata[7:0]);
          end
        end
        ARS_IDX_COMPARATOR: begin
          if (st.wstrb[0]) begin
            next_st.comparator_reference_setting = ars_mask(st.wdata[7:0]);
          end
        end
        // Reserved holes and the status word accept and discard writes
        ARS_IDX_RSVD_A, ARS_IDX_RSVD_B, ARS_IDX_STATUS: begin
          next_st.bresp = ARS_RESP_OKAY;
        end
        default: begin
          next_st.bresp = ARS_RESP_SLVERR;
        end
      endcase
    end else if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = ARS_RESP_OKAY;
      next_st.rdata  = '0;
      case (rd_index)
        ARS_IDX_CONVERTER: begin
          next_st.rdata = ars_word(st.converter_reference_setting);
        end
        ARS_IDX_DAC: begin
          next_st.rdata = ars_word(st.dac_reference_setting);
        end
        ARS_IDX_COMPARATOR: begin
          next_st.rdata = ars_word(st.comparator_reference_setting);
        end
        ARS_IDX_STATUS: begin
          next_st.rdata[ARS_ST_EN_LSB]     = converter_ref.source_enable;
          next_st.rdata[ARS_ST_EN_LSB + 1] = dac_ref.source_enable;
          next_st.rdata[ARS_ST_EN_LSB + 2] = comparator_drive.source_enable;
          next_st.rdata[ARS_ST_REQ_LSB +: ARS_REQ_W] = request_sync;
        end
        ARS_IDX_RSVD_A, ARS_IDX_RSVD_B: begin
          next_st.rdata = '0;
        end
        default: begin
          next_st.rresp = ARS_RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.converter_reference_setting  <= ars_ref_reg_s'(ARS_REF_RESET);
      st.dac_reference_setting        <= ars_ref_reg_s'(ARS_REF_RESET);
      st.comparator_reference_setting <= ars_ref_reg_s'(ARS_REF_RESET);
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// *** tb/ars_consumer_model.sv ***
// Purpose: Analog consumers raising reference requests toward the bank.
// Assumes: want is set by the bench; requests are levels.
// Notes:   LAG models a slow consumer; requests change just after an edge.
`timescale 1ns/100ps
`default_nettype none
module ars_consumer_model #(
  parameter int LAG = 2
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [5:0] want,
  output logic      [5:0] req
);
  logic [5:0] pipe [LAG];
  always_ff @(posedge clk) begin
    pipe[0] <= srst ? 6'h00 : want;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign req = pipe[LAG-1];
endmodule
`default_nettype wire

// *** tb/ars_reference_bank_asserts.sv ***
// Purpose: Port-level checks of the reference select bank.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Routing checks skip the edge right after reset, outputs being registered.
`timescale 1ns/100ps
`default_nettype none
module ars_reference_bank_asserts (
  input wire logic                                        clk,
  input wire logic                                        srst,
  input wire ars_pkg::ars_axi_req_s                       axi_req,
  input wire ars_pkg::ars_axi_rsp_s                       axi_rsp,
  input wire logic                                        converter_request,
  input wire ars_pkg::ars_ref_out_s                       converter_ref,
  input wire ars_pkg::ars_ref_out_s                       dac_ref,
  input wire ars_pkg::ars_ref_out_s [ars_pkg::ARS_NUM_CMP-1:0] comparator_ref
);
  import ars_pkg::*;
  logic [7:0] ar_q;
  always_ff @(posedge clk) begin
    if (axi_req.arvalid && axi_rsp.arready) begin
      ar_q <= axi_req.araddr;
    end
  end
  function automatic logic ok(ars_ref_out_s r);
    logic [2:0] c;
    c = r.level_select;
    return r.internal_level == ((c < 4) ? 4'h1 << c : 4'h0) && r.route_supply == (c == 5)
      && r.route_external_pin == (c == 6) && r.code_reserved == (c == 4 || c == 7);
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_route; !$past(srst) |-> ok(converter_ref) && ok(dac_ref) && ok(comparator_ref[0]);
  endproperty
  a_route: assert property (p_route) else $error("routing wrong");
  property p_cmp_same; comparator_ref[1] == comparator_ref[0] && comparator_ref[2] ==
    comparator_ref[0] && comparator_ref[3] == comparator_ref[0]; endproperty
  a_cmp_same: assert property (p_cmp_same) else $error("comparators differ");
  property p_conv_req; converter_request [*4] |-> converter_ref.source_enable; endproperty
  a_conv_req: assert property (p_conv_req) else $error("no enable");
  property p_reset; $fell(srst) |=> {converter_ref.level_select, dac_ref.level_select,
    comparator_ref[0].level_select} == 9'h000; endproperty
  a_reset: assert property (p_reset) else $error("reset level wrong");
  property p_wr; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##[1:2] axi_rsp.bvalid; endproperty
  a_wr: assert property (p_wr) else $error("no write response");
  property p_rd; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  property p_rhold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rsv; axi_rsp.rvalid && ar_q[7:2] inside {6'h00, 6'h02, 6'h04}
    |-> axi_rsp.rdata[31:8] == 24'h000000 && axi_rsp.rdata[6:3] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits set");
endmodule
bind ars_reference_bank ars_reference_bank_asserts u_ars_reference_bank_asserts (
  .clk(clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .converter_request(converter_request), .converter_ref(converter_ref), .dac_ref(dac_ref),
  .comparator_ref(comparator_ref));
`default_nettype wire

// *** tb/ars_reference_bank_tb.sv ***
// Purpose: Register and request checks of the reference select bank.
// Assumes: AXI4-Lite master waits for every handshake; 100 ns clock.
// Notes:   Handshakes are judged at the falling edge, where inputs are settled.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ars_reference_bank_tb;
  import ars_pkg::*;
  logic clk, srst;
  ars_axi_req_s req;
  ars_axi_rsp_s rsp;
  logic [5:0] want;
  wire logic [5:0] creq;
  ars_ref_out_s conv_o, dac_o;
  ars_ref_out_s [ARS_NUM_CMP-1:0] cmp_o;
  logic [31:0] rd_d;
  logic [1:0] rsp_c;
  int mismatches = 0;
  int checked = 0;
  ars_reference_bank u_ars_reference_bank (.clk(clk), .srst(srst), .axi_req(req),
    .axi_rsp(rsp), .converter_request(creq[0]), .dac_request(creq[1]),
    .comparator_request(creq[5:2]), .converter_ref(conv_o), .dac_ref(dac_o),
    .comparator_ref(cmp_o));
  ars_consumer_model u_ars_consumer_model (.clk(clk), .srst(srst), .want(want), .req(creq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic ars_ref_out_s ref_exp(input int c, input logic en);
    ars_ref_out_s r;
    r = '0;
    r.source_enable = en;
    r.level_select = ars_level_e'(c[2:0]);
    r.internal_level = (c < 4) ? 4'h1 << c : 4'h0;
    r.route_supply = (c == 5);
    r.route_external_pin = (c == 6);
    r.code_reserved = (c == 4 || c == 7);
    return r;
  endfunction
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      rsp_c = rsp.bresp;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) begin
        req.bready <= 1'b0;
        return;
      end
    end
    mismatches++;
    end_of_test();
  endtask
  // A non-zero lag holds rready low so the slave must keep its read data standing
  task automatic rd(input logic [7:0] a, input int lag = 0);
    logic ar, r;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= (lag == 0);
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ar = req.arvalid & rsp.arready;
      r = rsp.rvalid & req.rready;
      rd_d = rsp.rdata;
      rsp_c = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
      if (r) begin
        req.rready <= 1'b0;
        return;
      end
      if (n + 1 >= lag) req.rready <= 1'b1;
    end
    mismatches++;
    end_of_test();
  endtask
  // Three sync and output edges plus the consumer lag, with margin
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask
  initial begin
    srst = 1'b1;
    req = '0;
    want = 6'h00;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 8));
      `CHK(rd_d, 32'h0)
    end
    `CHK(conv_o, ref_exp(0, 1'b0))
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'hffffff78 | c);
      `CHK(rsp_c, ARS_RESP_OKAY)
      wr(8'h08, {29'h0, 3'(7 - c)});
      rd(8'h00);
      `CHK(rd_d, {29'h0, 3'(c)})
      settle();
      `CHK(conv_o, ref_exp(c, 1'b0))
      `CHK(dac_o, ref_exp(7 - c, 1'b0))
    end
    wr(8'h10, 32'h5);
    settle();
    for (int k = 0; k < ARS_NUM_CMP; k++) `CHK(cmp_o[k], ref_exp(5, 1'b0))
    wr(8'h04, 32'hff);
    `CHK(rsp_c, ARS_RESP_OKAY)
    rd(8'h04);
    `CHK(rd_d, 32'h0)
    rd(8'h40);
    `CHK(rsp_c, ARS_RESP_SLVERR)
    wr(8'h40, 32'h0);
    `CHK(rsp_c, ARS_RESP_SLVERR)
    @(posedge clk);
    want <= 6'h01;
    settle();
    `CHK(conv_o.source_enable, 1'b1)
    `CHK(dac_o.source_enable, 1'b0)
    @(posedge clk);
    want <= 6'h22;
    settle();
    `CHK(conv_o.source_enable, 1'b0)
    `CHK(dac_o.source_enable, 1'b1)
    for (int k = 0; k < ARS_NUM_CMP; k++) `CHK(cmp_o[k].source_enable, 1'b1)
    // Status word: enables {cmp, dac, conv} = 3'b110, synced requests 6'h22 from bit 4
    rd(8'h14);
    `CHK(rd_d, 32'h226)
    @(posedge clk);
    want <= 6'h00;
    wr(8'h08, 32'h80);
    rd(8'h08, 3);
    `CHK(rd_d, 32'h80)
    settle();
    `CHK(dac_o.source_enable, 1'b1)
    `CHK(cmp_o[0].source_enable, 1'b0)
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(8'h08);
    `CHK(rd_d, 32'h0)
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
